// ==== hdbx_map.vh ====
// Register offsets, field positions, reset values and timing counts of the buffer exchange block
`ifndef HDBX_MAP_VH
`define HDBX_MAP_VH
// Register addresses (8-bit space)
`define HDBX_TX_DATA0 8'h00
`define HDBX_TX_DATA1 8'h08
`define HDBX_RX_DATA0 8'h10
`define HDBX_RX_DATA1 8'h18
`define HDBX_TX_CTRL0 8'h20
`define HDBX_TX_CTRL1 8'h21
`define HDBX_RX_STATE0 8'h22
`define HDBX_RX_STATE1 8'h23
`define HDBX_SYSTEM_ERROR_WORD 8'h24
`define HDBX_MODE 8'h25
`define HDBX_COMMAND 8'h26
`define HDBX_IRQ_STAT 8'h27
`define HDBX_IRQ_MASK 8'h28
// Status word fields
`define HDBX_LEN_HI 3
`define HDBX_LEN_LO 0
`define HDBX_LEN_MAX 4'h8
`define HDBX_TX_SFRM 4
`define HDBX_TX_EFRM 5
`define HDBX_TX_FRAB 6
`define HDBX_RX_ERR_HI 5
`define HDBX_RX_ERR_LO 4
`define HDBX_RX_SFRM 6
`define HDBX_RX_EFRM 7
// Receive error codes
`define HDBX_ERR_NONE 2'h0
`define HDBX_ERR_CRC 2'h1
`define HDBX_ERR_ALIGN 2'h2
`define HDBX_ERR_ABORT 2'h3
// Mode register fields
`define HDBX_MODE_HDLC 0
`define HDBX_MODE_RATE_HI 2
`define HDBX_MODE_RATE_LO 1
// System error and interrupt bits
`define HDBX_ERR_TX_BIT 0
`define HDBX_ERR_RX_BIT 1
`define HDBX_IRQ_TX_BIT 0
`define HDBX_IRQ_RX_BIT 1
`define HDBX_IRQ_ERR_BIT 2
// Commands
`define HDBX_CMD_START 8'h01
`define HDBX_CMD_STOP 8'h02
// Baud rates and clock
`define HDBX_CLK_HZ 125000000
`define HDBX_BAUD_1200 1200
`define HDBX_BAUD_300 300
`define HDBX_BAUD_75 75
`define HDBX_RESET_VAL 8'h00
`endif

// ==== hdbx_baud_timer.v ====
// Baud tick generator selecting one of three nominal rates
`timescale 1ns/1ns
`default_nettype none
module hdbx_baud_timer #(
  parameter integer DIV_A = 104166,
  parameter integer DIV_B = 416666,
  parameter integer DIV_C = 1666666
) (
  // Clock and reset
  input wire ref_clk_i,
  input wire rst_i,
  // Control
  input wire run_i,
  input wire [1:0] rate_i,
  // Tick out
  output reg tick_o
);
  reg [21:0] count;
  reg [21:0] limit;

  // Pick the divider for the selected rate
  always @* begin
    case (rate_i)
      2'h0: limit = DIV_A[21:0] - 22'h1;
      2'h1: limit = DIV_B[21:0] - 22'h1;
      default: limit = DIV_C[21:0] - 22'h1;
    endcase
  end

  // Free count while running, one tick per baud period
  always @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      count <= 22'h0;
      tick_o <= 1'b0;
    end else if (!run_i) begin
      count <= 22'h0;
      tick_o <= 1'b0;
    end else if (count >= limit) begin
      count <= 22'h0;
      tick_o <= 1'b1;
    end else begin
      count <= count + 22'h1;
      tick_o <= 1'b0;
    end
  end
endmodule // hdbx_baud_timer
`default_nettype wire

// ==== hdbx_buffer_exchange.v ====
// Ping-pong transmit and receive buffer exchange between host and framer/deframer
// Summary of operation
// - Host sets tx word, modem clears it
// - Zero tx word means buffer free
// - Bad tx handshake raises tx error
// - Emptied tx buffer raises tx interrupt
// - Sync mode sends count bytes, 1..8
// - Byte count in bits 3:0
// - HDLC tx honours abort; open, close unused
// - Tx holds bit one baud period
// - Sync rx stores bytes and count
// - HDLC rx reports CRC, abort, alignment
// - Rx writes status and interrupts at one edge
// - Rx checks buffer free before filling
// - Host clears rx word, bad clear errors
// - Rx samples one bit per baud
`timescale 1ns/1ns
`default_nettype none
`include "hdbx_map.vh"
module hdbx_buffer_exchange #(
  parameter integer DIV_1200 = `HDBX_CLK_HZ / `HDBX_BAUD_1200,
  parameter integer DIV_300 = `HDBX_CLK_HZ / `HDBX_BAUD_300,
  parameter integer DIV_75 = `HDBX_CLK_HZ / `HDBX_BAUD_75
) (
  // Clock and reset
  input wire ref_clk_i,
  input wire rst_i,
  // Register port
  input wire [7:0] addr_i,
  input wire [7:0] wdata_i,
  input wire wr_i,
  input wire rd_i,
  output reg [7:0] rdata_o,
  // Serial line
  output reg tx_bit_o,
  input wire rx_bit_i,
  // Framing events from the line deframer
  input wire rx_frame_start_i,
  input wire rx_frame_end_i,
  input wire [1:0] rx_frame_err_i,
  // Interrupt
  output reg irq_o
);
  reg [7:0] tx_mem [0:15];
  reg [7:0] rx_mem [0:15];
  reg [7:0] tx_ctrl [0:1];
  reg [7:0] rx_state [0:1];
  reg [1:0] system_error_word;
  reg [2:0] irq_stat;
  reg [2:0] irq_mask;
  reg [2:0] mode;
  reg tx_run;
  reg tx_sel;
  reg [3:0] tx_idx;
  reg [2:0] tx_bit;
  reg [7:0] tx_shift;
  reg tx_busy;
  reg rx_sel;
  reg [3:0] rx_idx;
  reg [2:0] rx_bit;
  reg [7:0] rx_shift;
  reg rx_s1;
  reg rx_s2;
  reg rx_sfrm;
  reg rx_drop;
  wire baud_tick;
  wire [3:0] tx_len;
  wire tx_done_ev;
  wire rx_byte_ev;
  wire rx_close;
  wire rx_fill_ev;
  wire tx_word_bad;
  wire rx_clear_bad;
  wire tx_free_ev;
  wire rx_post_ev;
  reg [7:0] next_rx_word;
  wire [2:0] ev;
  integer i;
  integer j;

  hdbx_baud_timer #(
    .DIV_A(DIV_1200),
    .DIV_B(DIV_300),
    .DIV_C(DIV_75)
  ) u_baud (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .run_i(1'b1),
    .rate_i(mode[`HDBX_MODE_RATE_HI:`HDBX_MODE_RATE_LO]),
    .tick_o(baud_tick)
  );

  // Current transmit buffer length and end-of-buffer detection
  assign tx_len = tx_ctrl[tx_sel][`HDBX_LEN_HI:`HDBX_LEN_LO];
  assign tx_done_ev = tx_busy && baud_tick && (tx_bit == 3'h7) && (tx_idx[2:0] == tx_len[2:0] - 3'h1);
  // Receive byte completes on the eighth sampled bit
  assign rx_byte_ev = baud_tick && (rx_bit == 3'h7) && !rx_drop;
  assign rx_close = mode[`HDBX_MODE_HDLC] ? rx_frame_end_i : 1'b0;
  assign rx_fill_ev = rx_byte_ev && ((rx_idx[2:0] == 3'h7) || rx_close) || (rx_close && rx_idx[2:0] != 3'h0);

  // Bad order, busy word, bad length or nonzero spare bit in a host write
  assign tx_word_bad = wr_i && (addr_i == `HDBX_TX_CTRL0 || addr_i == `HDBX_TX_CTRL1) &&
    (tx_ctrl[addr_i[0]] != 8'h00 || wdata_i == 8'h00 || wdata_i[7] ||
    (!mode[`HDBX_MODE_HDLC] && wdata_i[7:4] != 4'h0) ||
    (!wdata_i[`HDBX_TX_FRAB] && wdata_i[3:0] > `HDBX_LEN_MAX) ||
    (addr_i[0] != tx_sel && tx_ctrl[tx_sel] == 8'h00));
  assign rx_clear_bad = wr_i && (addr_i == `HDBX_RX_STATE0 || addr_i == `HDBX_RX_STATE1) &&
    (wdata_i != 8'h00 || rx_state[addr_i[0]] == 8'h00);
  // Modem frees an emptied word, or a data-less one at once
  assign tx_free_ev = tx_done_ev || (tx_run && baud_tick && !tx_busy && tx_ctrl[tx_sel] != 8'h00 &&
    (tx_ctrl[tx_sel][`HDBX_TX_FRAB] || tx_len == 4'h0));
  assign rx_post_ev = rx_fill_ev && !rx_drop;
  // Events that set the sticky interrupt status
  assign ev[`HDBX_IRQ_TX_BIT] = tx_free_ev;
  assign ev[`HDBX_IRQ_RX_BIT] = rx_post_ev;
  assign ev[`HDBX_IRQ_ERR_BIT] = tx_word_bad || rx_clear_bad;

  // Build the receive status word for the buffer being closed
  always @* begin
    next_rx_word = 8'h00;
    next_rx_word[`HDBX_LEN_HI:`HDBX_LEN_LO] = rx_byte_ev ? {1'b0, rx_idx[2:0]} + 4'h1 : {1'b0, rx_idx[2:0]};
    if (mode[`HDBX_MODE_HDLC]) begin
      next_rx_word[`HDBX_RX_SFRM] = rx_sfrm;
      next_rx_word[`HDBX_RX_EFRM] = rx_close;
      next_rx_word[`HDBX_RX_ERR_HI:`HDBX_RX_ERR_LO] = rx_close ? rx_frame_err_i : `HDBX_ERR_NONE;
    end
  end

  // Line input synchroniser
  always @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rx_s1 <= 1'b0;
      rx_s2 <= 1'b0;
    end else begin
      rx_s1 <= rx_bit_i;
      rx_s2 <= rx_s1;
    end
  end

  // Transmit framer: one bit held per baud period, ping-pong buffers
  always @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      tx_sel <= 1'b0;
      tx_idx <= 4'h0;
      tx_bit <= 3'h0;
      tx_shift <= 8'h00;
      tx_busy <= 1'b0;
      tx_bit_o <= 1'b1;
    end else if (!tx_run) begin
      tx_sel <= 1'b0;
      tx_idx <= 4'h0;
      tx_bit <= 3'h0;
      tx_busy <= 1'b0;
      tx_bit_o <= 1'b1;
    end else if (baud_tick) begin
      if (!tx_busy) begin
        tx_bit_o <= 1'b1;
        // Abort-only or empty words close at once without data
        if (tx_ctrl[tx_sel] != 8'h00 && !tx_ctrl[tx_sel][`HDBX_TX_FRAB] && tx_len != 4'h0) begin
          tx_busy <= 1'b1;
          tx_idx <= 4'h0;
          tx_bit <= 3'h0;
          tx_shift <= tx_mem[{tx_sel, 3'h0}];
        end else if (tx_ctrl[tx_sel] != 8'h00) begin
          // A data-less word is freed at once, so the turn passes on
          tx_sel <= ~tx_sel;
        end
      end else begin
        tx_bit_o <= tx_shift[0];
        tx_shift <= {1'b0, tx_shift[7:1]};
        tx_bit <= tx_bit + 3'h1;
        if (tx_bit == 3'h7) begin
          if (tx_done_ev) begin
            tx_busy <= 1'b0;
            tx_sel <= ~tx_sel;
          end else begin
            tx_idx <= tx_idx + 4'h1;
            tx_shift <= tx_mem[{tx_sel, tx_idx[2:0] + 3'h1}];
          end
        end
      end
    end
  end

  // Receive deframer: one sample per baud period into the free buffer
  always @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rx_sel <= 1'b0;
      rx_idx <= 4'h0;
      rx_bit <= 3'h0;
      rx_shift <= 8'h00;
      rx_sfrm <= 1'b0;
      rx_drop <= 1'b0;
      for (j = 0; j < 16; j = j + 1) begin
        rx_mem[j] <= 8'h00;
      end
    end else begin
      if (baud_tick) begin
        rx_shift <= {rx_s2, rx_shift[7:1]};
        rx_bit <= rx_bit + 3'h1;
        if (rx_bit == 3'h0 && rx_idx == 4'h0) begin
          rx_drop <= (rx_state[rx_sel] != 8'h00);
        end
      end
      if (rx_byte_ev) begin
        rx_mem[{rx_sel, rx_idx[2:0]}] <= {rx_s2, rx_shift[7:1]};
        rx_idx <= rx_idx + 4'h1;
      end
      if (rx_fill_ev) begin
        rx_idx <= 4'h0;
        rx_sel <= ~rx_sel;
        rx_sfrm <= 1'b0;
      end
      // A start in the closing cycle belongs to the next buffer
      if (rx_frame_start_i) begin
        rx_sfrm <= 1'b1;
      end
    end
  end

  // Host registers, handshake words, errors and interrupts
  always @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      tx_ctrl[0] <= `HDBX_RESET_VAL;
      tx_ctrl[1] <= `HDBX_RESET_VAL;
      rx_state[0] <= `HDBX_RESET_VAL;
      rx_state[1] <= `HDBX_RESET_VAL;
      system_error_word <= 2'h0;
      irq_stat <= 3'h0;
      irq_mask <= 3'h0;
      mode <= 3'h0;
      tx_run <= 1'b0;
      rdata_o <= 8'h00;
      irq_o <= 1'b0;
      for (i = 0; i < 16; i = i + 1) begin
        tx_mem[i] <= 8'h00;
      end
    end else begin
      if (wr_i) begin
        if (addr_i[7:4] == 4'h0) begin
          tx_mem[addr_i[3:0]] <= wdata_i;
        end
        case (addr_i)
          `HDBX_TX_CTRL0, `HDBX_TX_CTRL1: begin
            if (tx_word_bad) begin
              system_error_word[`HDBX_ERR_TX_BIT] <= 1'b1;
            end
            tx_ctrl[addr_i[0]] <= wdata_i;
          end
          `HDBX_RX_STATE0, `HDBX_RX_STATE1: begin
            if (rx_clear_bad) begin
              system_error_word[`HDBX_ERR_RX_BIT] <= 1'b1;
            end else begin
              rx_state[addr_i[0]] <= 8'h00;
            end
          end
          `HDBX_MODE: mode <= wdata_i[2:0];
          `HDBX_IRQ_MASK: irq_mask <= wdata_i[2:0];
          `HDBX_COMMAND: begin
            if (wdata_i == `HDBX_CMD_START) begin
              tx_run <= 1'b1;
            end else if (wdata_i == `HDBX_CMD_STOP) begin
              tx_run <= 1'b0;
            end
          end
          default: ;
        endcase
      end
      // Modem frees the emptied transmit word
      if (tx_free_ev) begin
        tx_ctrl[tx_sel] <= 8'h00;
      end
      // Status word and its interrupt bit settle in the same edge
      if (rx_post_ev) begin
        rx_state[rx_sel] <= next_rx_word;
      end
      // Read data and clear-on-read of the interrupt status, set wins
      rdata_o <= 8'h00;
      if (rd_i) begin
        if (addr_i[7:4] == 4'h0) begin
          rdata_o <= tx_mem[addr_i[3:0]];
        end else if (addr_i[7:4] == 4'h1) begin
          rdata_o <= rx_mem[addr_i[3:0]];
        end else begin
          case (addr_i)
            `HDBX_TX_CTRL0: rdata_o <= tx_ctrl[0];
            `HDBX_TX_CTRL1: rdata_o <= tx_ctrl[1];
            `HDBX_RX_STATE0: rdata_o <= rx_state[0];
            `HDBX_RX_STATE1: rdata_o <= rx_state[1];
            `HDBX_SYSTEM_ERROR_WORD: rdata_o <= {6'h00, system_error_word};
            `HDBX_MODE: rdata_o <= {5'h00, mode};
            `HDBX_COMMAND: rdata_o <= {7'h00, tx_run};
            `HDBX_IRQ_STAT: rdata_o <= {5'h00, irq_stat};
            `HDBX_IRQ_MASK: rdata_o <= {5'h00, irq_mask};
            default: rdata_o <= 8'h00;
          endcase
        end
      end
      if (rd_i && addr_i == `HDBX_IRQ_STAT) begin
        irq_stat <= ev;
        irq_o <= |(ev & irq_mask);
      end else begin
        irq_stat <= irq_stat | ev;
        irq_o <= |((irq_stat | ev) & irq_mask);
      end
      if (rd_i && addr_i == `HDBX_SYSTEM_ERROR_WORD) begin
        system_error_word <= 2'h0;
      end
    end
  end
endmodule // hdbx_buffer_exchange
`default_nettype wire

// ==== hdbx_assertions.sv ====
// Port checker for the buffer exchange block
`timescale 1ns/1ns
`default_nettype none
module hdbx_checker (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_i,
  // Register port
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [7:0] rdata_o,
  // Line and interrupt
  input wire logic tx_bit_o,
  input wire logic irq_o
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  // Read of the error word, write of a tx word
  sequence s_err_rd;
    rd_i && addr_i == 8'h24;
  endsequence
  sequence s_tx_wr;
    wr_i && (addr_i == 8'h20 || addr_i == 8'h21);
  endsequence
  a_tx_bad_word: assert property (s_tx_wr ##0 wdata_i[7] ##1 s_err_rd |=> rdata_o[0])
    else $error("tx error flag missing");
  a_tx_count_max: assert property (s_tx_wr ##0 wdata_i == 8'h09 ##1 s_err_rd |=> rdata_o[0])
    else $error("count nine not flagged");
  a_rx_bad_clear: assert property (wr_i && addr_i == 8'h22 && wdata_i != 8'h00 ##1 s_err_rd |=> rdata_o[1])
    else $error("rx error flag missing");
  a_tx_bit_hold: assert property ($changed(tx_bit_o) |=> $stable(tx_bit_o) [*7])
    else $error("tx bit too short");
  a_rdata_quiet: assert property (!$past(rd_i) |-> rdata_o == 8'h00)
    else $error("read data outside its cycle");
  a_unmapped_zero: assert property (rd_i && addr_i > 8'h28 |=> rdata_o == 8'h00)
    else $error("unmapped read not zero");
  a_mask_off: assert property (wr_i && addr_i == 8'h28 && wdata_i == 8'h00 |=> ##1 !irq_o)
    else $error("masked interrupt high");
  a_reset_idle: assert property ($fell(rst_i) |-> tx_bit_o && !irq_o)
    else $error("outputs not idle after reset");
endmodule // hdbx_checker
bind hdbx_buffer_exchange hdbx_checker chk_u (.ref_clk_i, .rst_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
  .tx_bit_o, .irq_o);
`default_nettype wire

// ==== hdbx_host_model.sv ====
// Host processor model driving the register port
`timescale 1ns/1ns
`default_nettype none
module hdbx_host_model (
  // Clock
  input wire logic ref_clk_i,
  // Register port
  output var logic [7:0] addr_o,
  output var logic [7:0] wdata_o,
  output var logic wr_o,
  output var logic rd_o,
  input wire logic [7:0] rdata_i
);
  // Bus idle from time zero
  initial begin
    addr_o = 8'h00;
    wdata_o = 8'h00;
    wr_o = 1'b0;
    rd_o = 1'b0;
  end
  // One-cycle write; keep lets a read follow with no gap
  task wr(input logic [7:0] a, input logic [7:0] d, input bit keep = 0);
    @(posedge ref_clk_i);
    wr_o <= 1'b1;
    addr_o <= a;
    wdata_o <= d;
    if (!keep) begin
      @(posedge ref_clk_i);
      wr_o <= 1'b0;
    end
  endtask
  // One-cycle read; data taken in the next cycle
  task rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge ref_clk_i);
    wr_o <= 1'b0;
    rd_o <= 1'b1;
    addr_o <= a;
    @(posedge ref_clk_i);
    rd_o <= 1'b0;
    // Data stand for one cycle; take them at its closing edge
    @(posedge ref_clk_i);
    v = rdata_i;
  endtask
endmodule // hdbx_host_model
`default_nettype wire

// ==== test_host_data_buffer_exchange.sv ====
// Self-checking bench for the buffer exchange block
`timescale 1ns/1ns
`default_nettype none
`define HDBX_CHK(got, exp) begin checked++; if ((got) !== (exp)) begin failures++; \
  $display("mismatch at %0t got %h expected %h", $time, got, exp); end end
module test_host_data_buffer_exchange;
  logic ref_clk_i, rst_i, wr_i, rd_i, tx_bit_o, rx_bit_i, rx_frame_start_i, rx_frame_end_i, irq_o;
  logic [7:0] addr_i, wdata_i, rdata_o, v;
  logic [1:0] rx_frame_err_i;
  int failures = 0, checked = 0, cycles = 0, n;
  // Short baud divisors keep the run brief
  hdbx_buffer_exchange #(.DIV_1200(8), .DIV_300(12), .DIV_75(16)) dut_u (.ref_clk_i, .rst_i, .addr_i, .wdata_i,
    .wr_i, .rd_i, .rdata_o, .tx_bit_o, .rx_bit_i, .rx_frame_start_i, .rx_frame_end_i, .rx_frame_err_i, .irq_o);
  hdbx_host_model host_u (.ref_clk_i, .addr_o(addr_i), .wdata_o(wdata_i), .wr_o(wr_i), .rd_o(rd_i), .rdata_i(rdata_o));
  // Clock
  initial begin
    ref_clk_i = 1'b0;
    forever #4 ref_clk_i = ~ref_clk_i;
  end
  // Hang guard
  always @(posedge ref_clk_i) begin
    cycles++;
    if (cycles == 30000) begin
      failures++;
      close_out;
    end
  end
  task close_out;
    $display("comparisons %0d mismatches %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task reset_dut;
    rst_i <= 1'b1;
    repeat (16) @(posedge ref_clk_i);
    rst_i <= 1'b0;
  endtask
  task rd_chk(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
    host_u.rd(a, v);
    `HDBX_CHK(v & m, e)
  endtask
  task wait_irq;
    for (n = 0; n < 3000 && irq_o !== 1'b1; n++) @(posedge ref_clk_i);
    `HDBX_CHK(irq_o, 1'b1)
  endtask
  // Reset values and an unmapped read
  task t_reset_values;
    reset_dut;
    for (int a = 8'h20; a <= 8'h28; a++) rd_chk(a[7:0], 8'hff, 8'h00);
    rd_chk(8'h30, 8'hff, 8'h00);
    `HDBX_CHK(tx_bit_o, 1'b1)
    $display("reset test done");
  endtask
  // Improper status words raise error flags
  task t_bad_words;
    reset_dut;
    host_u.wr(8'h20, 8'h81, 1);
    rd_chk(8'h24, 8'hff, 8'h01);
    reset_dut;
    host_u.wr(8'h20, 8'h09, 1);
    rd_chk(8'h24, 8'hff, 8'h01);
    host_u.wr(8'h22, 8'h05, 1);
    rd_chk(8'h24, 8'hff, 8'h02);
    $display("bad word test done");
  endtask
  // Two zero bytes at the middle rate leave as sixteen baud periods low
  task t_sync_tx;
    reset_dut;
    host_u.wr(8'h25, 8'h02);
    host_u.wr(8'h28, 8'h01);
    host_u.wr(8'h00, 8'h00);
    host_u.wr(8'h01, 8'h00);
    host_u.wr(8'h20, 8'h02);
    host_u.wr(8'h26, 8'h01);
    for (n = 0; n < 500 && tx_bit_o !== 1'b0; n++) @(negedge ref_clk_i);
    for (n = 0; n < 500 && tx_bit_o === 1'b0; n++) @(negedge ref_clk_i);
    `HDBX_CHK(n, 16 * 12)
    wait_irq;
    rd_chk(8'h27, 8'h01, 8'h01);
    rd_chk(8'h20, 8'hff, 8'h00);
    host_u.wr(8'h26, 8'h02);
    rd_chk(8'h26, 8'hff, 8'h00);
    $display("sync tx test done");
  endtask
  // Slow receive fills both buffers, a full pair drops data, host clears, mask silences
  task t_sync_rx;
    reset_dut;
    host_u.wr(8'h25, 8'h04);
    host_u.wr(8'h28, 8'h02);
    host_u.wr(8'h00, 8'hff);
    host_u.wr(8'h20, 8'h01);
    host_u.wr(8'h26, 8'h01);
    wait_irq;
    rd_chk(8'h22, 8'hff, 8'h08);
    rd_chk(8'h10, 8'hff, 8'hff);
    rd_chk(8'h27, 8'h02, 8'h02);
    wait_irq;
    rd_chk(8'h23, 8'hff, 8'h08);
    rd_chk(8'h27, 8'h02, 8'h02);
    // Longer than one buffer fill: nothing may land while both are held
    repeat (1200) @(posedge ref_clk_i);
    rd_chk(8'h27, 8'h02, 8'h00);
    host_u.wr(8'h22, 8'h00);
    rd_chk(8'h24, 8'h02, 8'h00);
    host_u.wr(8'h22, 8'h00, 1);
    rd_chk(8'h24, 8'h02, 8'h02);
    host_u.wr(8'h28, 8'h00);
    repeat (2) @(posedge ref_clk_i);
    `HDBX_CHK(irq_o, 1'b0)
    $display("sync rx test done");
  endtask
  // Every frame error code, buffers taken in turn
  task t_hdlc_rx;
    reset_dut;
    host_u.wr(8'h25, 8'h01);
    host_u.wr(8'h28, 8'h02);
    host_u.wr(8'h20, 8'h40);
    host_u.wr(8'h26, 8'h01);
    for (int e = 0; e < 4; e++) begin
      rx_frame_start_i <= 1'b1;
      @(posedge ref_clk_i);
      rx_frame_start_i <= 1'b0;
      repeat (70) @(posedge ref_clk_i);
      rx_frame_end_i <= 1'b1;
      rx_frame_err_i <= e[1:0];
      @(posedge ref_clk_i);
      rx_frame_end_i <= 1'b0;
      wait_irq;
      rd_chk(8'h27, 8'h02, 8'h02);
      rd_chk(8'h22 + e[0], 8'hf0, {2'b11, e[1:0], 4'h0});
      host_u.wr(8'h22 + e[0], 8'h00);
    end
    $display("hdlc rx test done");
  endtask
  // Main sequence
  initial begin
    rst_i = 1'b1;
    rx_bit_i = 1'b1;
    rx_frame_start_i = 1'b0;
    rx_frame_end_i = 1'b0;
    rx_frame_err_i = 2'h0;
    t_reset_values;
    t_bad_words;
    t_sync_tx;
    t_sync_rx;
    t_hdlc_rx;
    close_out;
  end
endmodule // test_host_data_buffer_exchange
`default_nettype wire
